// ### verilog/timer_pkg.sv
// Purpose: shared constants and types of the standard timer block
// Assumes: 32-bit APB register words, one aligned word per register
// Notes: control byte keeps the mode/pin/clear bit order of the timer core

package timer_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_DUTY = 8'h0C;
	localparam logic [7:0] OFS_PERIOD = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_EN_BIT = 3;
	localparam int CTRL_DIV_LSB = 8;
	localparam int STAT_A_BIT = 0;
	localparam int STAT_P_BIT = 1;
	localparam int PERIOD_SHIFT = 8;

	////////////////////////////////////////////////////////////////////////////
	// reset values and widths
	localparam int CNT_W = 16;
	localparam int PER_W = 8;
	localparam logic [15:0] DUTY_RST = 16'h0000;
	localparam logic [7:0] PERIOD_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [16:0] FULL_SPAN = 17'h10000;

	////////////////////////////////////////////////////////////////////////////
	// operating modes and pin functions
	typedef enum logic [1:0] {
		MODE_COMPARE = 2'b00,
		MODE_CAPTURE = 2'b01,
		MODE_PWM = 2'b10,
		MODE_TIMER = 2'b11
	} mode_t;

	typedef enum logic [1:0] {
		PIN_HOLD = 2'b00,
		PIN_LOW = 2'b01,
		PIN_HIGH = 2'b10,
		PIN_TOGGLE = 2'b11
	} cmp_fn_t;

	typedef enum logic [1:0] {
		PWM_FORCE_OFF = 2'b00,
		PWM_FORCE_ON = 2'b01,
		PWM_WAVE = 2'b10,
		PWM_ONE_SHOT = 2'b11
	} pwm_fn_t;

	// mode control byte, msb first
	typedef struct packed {
		logic mode_select_hi;
		logic mode_select_lo;
		logic pin_function_hi;
		logic pin_function_lo;
		logic output_initial_level;
		logic output_invert;
		logic duty_period_swap;
		logic clear_source_select;
	} mode_ctrl_t;

endpackage

// ### verilog/tick_divider.sv
// Purpose: one-cycle timer clock enable from the system clock
// Assumes: ratio is held steady while running
// Notes: a tick every ratio+1 cycles; restart realigns the phase
`timescale 1ns/1ns

module tick_divider #(
	parameter int DIV_W = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic restart,
	input wire logic [DIV_W-1:0] ratio,
	output logic tick
);

	logic [DIV_W-1:0] div_cnt_ff;

	generate
		if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
			$error("tick_divider: DIV_W must be 1 to 16");
		end
	endgenerate

	// strobe is combinational so the counter sees it in the same cycle
	assign tick = run && (div_cnt_ff == ratio);

	// phase counter, parked at zero while stopped
	always_ff @(posedge sys_clk) begin
		if (!reset_n || restart || !run || tick) begin
			div_cnt_ff <= '0;
		end else begin
			div_cnt_ff <= div_cnt_ff + DIV_W'(1);
		end
	end

endmodule

// ### verilog/standard_timer.sv
// Purpose: compare-match, timer/counter and edge-aligned PWM timer with APB registers
// Assumes: all inputs synchronous to sys_clk; zero-wait APB slave
// Notes: capture and single-pulse modes are not served here
`timescale 1ns/1ns

module standard_timer
	import timer_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int DIV_W = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic timer_output_pin,
	output logic timer_output_en
);

	////////////////////////////////////////////////////////////////////////////
	// state
	logic counter_enable_bit_ff;
	logic enable_prev_ff;
	logic [DIV_W-1:0] div_ratio_ff;
	mode_ctrl_t mode_ctrl_ff;
	logic [15:0] duty_compare_value_ff;
	logic [7:0] period_compare_high_byte_ff;
	logic [CNT_W-1:0] count_ff;
	logic match_a_flag_ff;
	logic match_p_flag_ff;
	logic pin_level_ff;
	logic timer_output_pin_ff;

	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic tick;
	logic en_rise;
	logic step;
	mode_t mode;
	logic [1:0] pin_fn;
	logic cmp_like;
	logic clear_by_a;
	logic [CNT_W-1:0] p_last;
	logic [CNT_W-1:0] a_last;
	logic p_hit;
	logic a_hit;
	logic clear_hit;
	logic a_set;
	logic p_set;
	logic [16:0] p_span;
	logic [16:0] pwm_period;
	logic [16:0] pwm_duty;
	logic wave_active;
	logic nxt_pin_level;

	generate
		if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
			$error("standard_timer: ADDR_W must be 8 to 32");
		end
		if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
			$error("standard_timer: DIV_W must be 1 to 16");
		end
	endgenerate

	// offset decode for the error answer; the read mux decodes the offsets in its own case
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == ADDR_W'(OFS_CTRL)) || (a == ADDR_W'(OFS_MODE))
			|| (a == ADDR_W'(OFS_COUNT)) || (a == ADDR_W'(OFS_DUTY))
			|| (a == ADDR_W'(OFS_PERIOD)) || (a == ADDR_W'(OFS_STATUS));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// APB slave: every access completes in its first access cycle
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign addr_ok = is_mapped(paddr);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	// read mux; narrow registers sit in low bits, the rest reads zero
	always_comb begin
		prdata = 32'h00000000;
		if (rd_en) begin
			unique case (paddr)
				ADDR_W'(OFS_CTRL): begin
					prdata[CTRL_EN_BIT] = counter_enable_bit_ff;
					prdata[CTRL_DIV_LSB +: DIV_W] = div_ratio_ff;
				end
				ADDR_W'(OFS_MODE): prdata[7:0] = mode_ctrl_ff;
				ADDR_W'(OFS_COUNT): prdata[CNT_W-1:0] = count_ff;
				ADDR_W'(OFS_DUTY): prdata[15:0] = duty_compare_value_ff;
				ADDR_W'(OFS_PERIOD): prdata[PER_W-1:0] = period_compare_high_byte_ff;
				ADDR_W'(OFS_STATUS): begin
					prdata[STAT_A_BIT] = match_a_flag_ff;
					prdata[STAT_P_BIT] = match_p_flag_ff;
				end
				default: prdata = 32'h00000000;
			endcase
		end
	end

	// control word: enable bit and timer clock divide ratio
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			counter_enable_bit_ff <= 1'b0;
			div_ratio_ff <= '0;
		end else if (wr_en && paddr == ADDR_W'(OFS_CTRL)) begin
			counter_enable_bit_ff <= pwdata[CTRL_EN_BIT];
			div_ratio_ff <= pwdata[CTRL_DIV_LSB +: DIV_W];
		end
	end

	// mode byte; changing it while running gives undefined waveforms
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			mode_ctrl_ff <= mode_ctrl_t'(MODE_RST);
		end else if (wr_en && paddr == ADDR_W'(OFS_MODE)) begin
			mode_ctrl_ff <= mode_ctrl_t'(pwdata[7:0]);
		end
	end

	// compare values
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			duty_compare_value_ff <= DUTY_RST;
			period_compare_high_byte_ff <= PERIOD_RST;
		end else if (wr_en) begin
			if (paddr == ADDR_W'(OFS_DUTY)) begin
				duty_compare_value_ff <= pwdata[15:0];
			end
			if (paddr == ADDR_W'(OFS_PERIOD)) begin
				period_compare_high_byte_ff <= pwdata[PER_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// enable edge and timer clock
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			enable_prev_ff <= 1'b0;
		end else begin
			enable_prev_ff <= counter_enable_bit_ff;
		end
	end

	assign en_rise = counter_enable_bit_ff && !enable_prev_ff;

	tick_divider #(
		.DIV_W(DIV_W)
	) u_tick (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.run(counter_enable_bit_ff),
		.restart(en_rise),
		.ratio(div_ratio_ff),
		.tick(tick)
	);

	assign step = counter_enable_bit_ff && tick && !en_rise;

	////////////////////////////////////////////////////////////////////////////
	// comparators
	assign mode = mode_t'({mode_ctrl_ff.mode_select_hi, mode_ctrl_ff.mode_select_lo});
	assign pin_fn = {mode_ctrl_ff.pin_function_hi, mode_ctrl_ff.pin_function_lo};
	assign cmp_like = (mode == MODE_COMPARE) || (mode == MODE_TIMER);

	// match on the last count before the boundary, so the boundary clears;
	// a zero period byte makes p_last all ones, i.e. plain overflow
	assign p_last = {period_compare_high_byte_ff, 8'h00} - 16'h0001;
	assign a_last = duty_compare_value_ff - 16'h0001;
	assign p_hit = (count_ff == p_last);
	assign a_hit = (count_ff == a_last);

	// PWM ignores clear select, the swap bit picks the clearing comparator
	always_comb begin
		if (mode == MODE_PWM) begin
			clear_by_a = mode_ctrl_ff.duty_period_swap;
		end else if (cmp_like) begin
			clear_by_a = mode_ctrl_ff.clear_source_select;
		end else begin
			clear_by_a = 1'b0;
		end
	end

	assign clear_hit = clear_by_a ? a_hit : p_hit;
	assign a_set = step && a_hit;
	// with A clear select in compare or timer mode, suppress the P flag even when the P match is reached
	assign p_set = step && p_hit && !(cmp_like && mode_ctrl_ff.clear_source_select);

	////////////////////////////////////////////////////////////////////////////
	// counter: zero on enable rise, hold while off
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			count_ff <= '0;
		end else if (en_rise) begin
			count_ff <= '0;
		end else if (step) begin
			count_ff <= clear_hit ? '0 : count_ff + 16'h0001;
		end
	end

	// match flags: hardware set beats a write-one clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			match_a_flag_ff <= 1'b0;
			match_p_flag_ff <= 1'b0;
		end else begin
			if (a_set) begin
				match_a_flag_ff <= 1'b1;
			end else if (wr_en && paddr == ADDR_W'(OFS_STATUS) && pwdata[STAT_A_BIT]) begin
				match_a_flag_ff <= 1'b0;
			end
			if (p_set) begin
				match_p_flag_ff <= 1'b1;
			end else if (wr_en && paddr == ADDR_W'(OFS_STATUS) && pwdata[STAT_P_BIT]) begin
				match_p_flag_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// PWM waveform; 17 bits so a zero byte can stand for 65536
	assign p_span = (period_compare_high_byte_ff == 8'h00) ? FULL_SPAN
		: {1'b0, period_compare_high_byte_ff, 8'h00};
	assign pwm_period = mode_ctrl_ff.duty_period_swap ? {1'b0, duty_compare_value_ff} : p_span;
	assign pwm_duty = mode_ctrl_ff.duty_period_swap ? p_span : {1'b0, duty_compare_value_ff};
	// count never reaches the period, so duty >= period stays active
	assign wave_active = ({1'b0, count_ff} < pwm_duty);

	////////////////////////////////////////////////////////////////////////////
	// output level before inversion
	always_comb begin
		nxt_pin_level = pin_level_ff;
		if (en_rise) begin
			nxt_pin_level = mode_ctrl_ff.output_initial_level;
		end else begin
			unique case (mode)
				MODE_COMPARE: begin
					// only comparator A moves the pin
					if (a_set) begin
						unique case (cmp_fn_t'(pin_fn))
							PIN_HOLD: nxt_pin_level = pin_level_ff;
							PIN_LOW: nxt_pin_level = 1'b0;
							PIN_HIGH: nxt_pin_level = 1'b1;
							PIN_TOGGLE: nxt_pin_level = !pin_level_ff;
						endcase
					end
				end
				MODE_PWM: begin
					// the waveform keeps running even when forced
					unique case (pwm_fn_t'(pin_fn))
						PWM_FORCE_OFF: nxt_pin_level = !mode_ctrl_ff.output_initial_level;
						PWM_FORCE_ON: nxt_pin_level = mode_ctrl_ff.output_initial_level;
						PWM_WAVE: nxt_pin_level = wave_active
							? mode_ctrl_ff.output_initial_level
							: !mode_ctrl_ff.output_initial_level;
						PWM_ONE_SHOT: nxt_pin_level = !mode_ctrl_ff.output_initial_level;
					endcase
				end
				MODE_CAPTURE, MODE_TIMER: nxt_pin_level = pin_level_ff;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pin_level_ff <= 1'b0;
			timer_output_pin_ff <= 1'b0;
		end else begin
			pin_level_ff <= nxt_pin_level;
			timer_output_pin_ff <= nxt_pin_level ^ mode_ctrl_ff.output_invert;
		end
	end

	assign timer_output_pin = timer_output_pin_ff;
	// pin is released in timer mode, so polarity and level have no effect there
	assign timer_output_en = (mode == MODE_COMPARE) || (mode == MODE_PWM);

	////////////////////////////////////////////////////////////////////////////
	// checks
	enable_zero_a:
	assert property (@(posedge sys_clk) disable iff (!reset_n)
		en_rise |=> (count_ff == 16'h0000))
		else $error("count not zero after enable rise");

	disabled_hold_a:
	assert property (@(posedge sys_clk) disable iff (!reset_n)
		(!counter_enable_bit_ff && !en_rise) |=> $stable(count_ff))
		else $error("count moved while disabled");

	count_step_a:
	assert property (@(posedge sys_clk) disable iff (!reset_n)
		(step && !clear_hit) |=> (count_ff == $past(count_ff) + 16'h0001))
		else $error("count did not step by one");

	period_clear_a:
	assert property (@(posedge sys_clk) disable iff (!reset_n)
		(step && !clear_by_a && count_ff == {period_compare_high_byte_ff, 8'h00} - 16'h0001)
		|=> (count_ff == 16'h0000))
		else $error("period match did not clear count");

	no_p_flag_a:
	assert property (@(posedge sys_clk) disable iff (!reset_n)
		(cmp_like && mode_ctrl_ff.clear_source_select && !match_p_flag_ff
		&& !(wr_en && paddr == ADDR_W'(OFS_MODE))) |=> !match_p_flag_ff)
		else $error("P flag raised with A clear select");

	a_flag_set_a:
	assert property (@(posedge sys_clk) disable iff (!reset_n)
		(step && a_hit) |=> match_a_flag_ff)
		else $error("A flag not raised on match");

	pin_reload_a:
	assert property (@(posedge sys_clk) disable iff (!reset_n)
		(en_rise && mode == MODE_COMPARE)
		|=> (timer_output_pin == ($past(mode_ctrl_ff.output_initial_level)
		^ $past(mode_ctrl_ff.output_invert))))
		else $error("pin not reloaded on enable rise");

	pin_nochange_a:
	assert property (@(posedge sys_clk) disable iff (!reset_n)
		(mode == MODE_COMPARE && pin_fn == 2'b00 && !en_rise) |=> $stable(pin_level_ff))
		else $error("pin moved with no-change function");

	full_duty_a:
	assert property (@(posedge sys_clk) disable iff (!reset_n)
		(mode == MODE_PWM && pin_fn == 2'b10 && !en_rise && pwm_duty >= pwm_period)
		|=> (timer_output_pin == ($past(mode_ctrl_ff.output_initial_level)
		^ $past(mode_ctrl_ff.output_invert))))
		else $error("full duty not held active");

	timer_release_a:
	assert property (@(posedge sys_clk) disable iff (!reset_n)
		(mode == MODE_TIMER) |-> !timer_output_en)
		else $error("pin driven in timer mode");

endmodule

// ### verif/pin_load.sv
// Purpose: load on the timer output pin that measures its waveform
// Assumes: the line has a pull-up while the timer releases it
// Notes: high time and period in sys_clk cycles, latched at each rise
`timescale 1ns/1ns

module pin_load (
	input wire logic sys_clk,
	input wire logic timer_output_pin,
	input wire logic timer_output_en,
	output logic line,
	output logic [31:0] hi_cnt,
	output logic [31:0] per_cnt,
	output logic [31:0] rises
);
	logic prev_ff = 1'b1;
	logic [31:0] run_ff = 32'h0;
	logic [31:0] hi_ff = 32'h0;
	logic [31:0] hi_cnt_ff = 32'h0;
	logic [31:0] per_cnt_ff = 32'h0;
	logic [31:0] rises_ff = 32'h0;

	// released pin floats up, never keeps the last driven level
	assign line = timer_output_en ? timer_output_pin : 1'b1;
	// one driver per result, so the counters live in this process alone
	assign hi_cnt = hi_cnt_ff;
	assign per_cnt = per_cnt_ff;
	assign rises = rises_ff;

	////////////////////////////////////////////////////////////////////////////
	// the first result after a restart is partial, so readers skip two rises
	always_ff @(posedge sys_clk) begin
		prev_ff <= line;
		if (line && !prev_ff) begin
			per_cnt_ff <= run_ff;
			hi_cnt_ff <= hi_ff;
			rises_ff <= rises_ff + 32'h1;
			run_ff <= 32'h1;
			hi_ff <= 32'h1;
		end else begin
			run_ff <= run_ff + 32'h1;
			hi_ff <= hi_ff + {31'h0, line};
		end
	end
endmodule

// ### verif/tb_top.sv
// Purpose: self-checking bench of the standard timer over APB
// Assumes: ratio 0 except one run, so a tick is one sys_clk cycle
// Notes: the overflow run dominates the cycle budget
`timescale 1ns/1ns

module tb_top import timer_pkg::*;;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic timer_output_pin;
	logic timer_output_en;
	logic line;
	logic [31:0] hi_cnt;
	logic [31:0] per_cnt;
	logic [31:0] rises;
	logic last_err;
	logic [7:0] offs[6] = '{OFS_CTRL, OFS_MODE, OFS_COUNT, OFS_DUTY, OFS_PERIOD, OFS_STATUS};
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	standard_timer #(.ADDR_W(8), .DIV_W(8)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_output_pin(timer_output_pin), .timer_output_en(timer_output_en));

	pin_load load (.sys_clk(sys_clk), .timer_output_pin(timer_output_pin),
		.timer_output_en(timer_output_en), .line(line), .hi_cnt(hi_cnt),
		.per_cnt(per_cnt), .rises(rises));

	////////////////////////////////////////////////////////////////////////////
	// report and bus tasks
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// entered just after a rising edge; request held until pready is sampled
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge, so a following call never reassigns psel in this step
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		chk(nm, exp, q);
	endtask

	function automatic mode_ctrl_t mk(input logic [1:0] md, input logic [1:0] fn,
		input logic oc, input logic pol, input logic dpx, input logic clr);
		mk = {md, fn, oc, pol, dpx, clr};
	endfunction

	// stop first, so every run starts from an enable rising edge
	task automatic start(input mode_ctrl_t m, input logic [15:0] duty, input logic [7:0] per,
		input logic [7:0] ratio);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_MODE, {24'h0, m});
		wr(OFS_DUTY, {16'h0, duty});
		wr(OFS_PERIOD, {24'h0, per});
		wr(OFS_STATUS, 32'h3);
		wr(OFS_CTRL, (32'(ratio) << CTRL_DIV_LSB) | (32'h1 << CTRL_EN_BIT));
	endtask

	task automatic meas(input string nm, input logic [31:0] hi, input logic [31:0] per);
		logic [31:0] r0;
		int n;
		r0 = rises;
		n = 0;
		while (rises - r0 < 3 && n < 5000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 5000) begin
			n_mismatch++;
			$display("[ERR] %s rises expected 3 seen %0d", nm, rises - r0);
		end
		chk({nm, " high"}, hi, hi_cnt);
		chk({nm, " period"}, per, per_cnt);
		$display("test %s done", nm);
	endtask

	// hang guard; the whole sequence needs about 77000 cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			$display("[ERR] timeout expected finish seen %0d cycles", cyc);
			n_mismatch++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [31:0] q;
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		chk("pin reset", 32'h0, {31'h0, timer_output_pin});
		foreach (offs[i]) rd(offs[i], 32'h0, "reset value");
		rd(8'h18, 32'h0, "unmapped read");
		chk("unmapped error", 32'h1, {31'h0, last_err});
		wr(OFS_PERIOD, 32'hFFFF_FFA5);
		rd(OFS_PERIOD, 32'h0000_00A5, "period byte");
		wr(OFS_COUNT, 32'h1234);
		rd(OFS_COUNT, 32'h0, "count read only");
		$display("test registers done");
		// codes none, low, high with start levels 1, 0 and 1 after invert
		for (int i = 0; i < 3; i++) begin
			start(mk(MODE_COMPARE, 2'(i), 1'(3'b011 >> i), 1'(3'b110 >> i), 1'b0, 1'b1),
				16'd40, 8'h00, 8'h00);
			repeat (3) @(posedge sys_clk);
			chk("pin initial", 32'(1'(3'b101 >> i)),
				{31'h0, timer_output_pin});
			repeat (60) @(posedge sys_clk);
			chk("pin on match", 32'(1'(3'b011 >> i)),
				{31'h0, timer_output_pin});
		end
		start(mk(MODE_COMPARE, PIN_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b0), 16'd16, 8'h01,
			8'h00);
		meas("cmp clear p", 256, 512);
		rd(OFS_STATUS, 32'h3, "both flags");
		start(mk(MODE_COMPARE, PIN_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b1), 16'd600, 8'h01, 8'h00);
		meas("cmp clear a", 600, 1200);
		rd(OFS_STATUS, 32'h1, "a flag only");
		wr(OFS_CTRL, 32'h0);
		apb(1'b0, OFS_COUNT, 32'h0, q);
		repeat (20) @(posedge sys_clk);
		rd(OFS_COUNT, q, "count held");
		wr(OFS_CTRL, 32'h1 << CTRL_EN_BIT);
		apb(1'b0, OFS_COUNT, 32'h0, q);
		chk("count restart", 32'h1, {31'h0, q < 32'd4});
		start(mk(MODE_TIMER, PIN_TOGGLE, 1'b1, 1'b0, 1'b0, 1'b1), 16'd40, 8'h00, 8'h00);
		repeat (100) @(posedge sys_clk);
		chk("pin released", 32'h0, {31'h0, timer_output_en});
		rd(OFS_STATUS, 32'h1, "timer flags");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_STATUS, 32'h1);
		rd(OFS_STATUS, 32'h0, "flag cleared");
		$display("test timer mode done");
		// clear select set in the last two runs (i = 2 and 3) must not change the wave
		for (int i = 0; i < 4; i++) begin
			start(mk(MODE_PWM, PWM_WAVE, i[0], i[1], 1'b0, i[1]), 16'd64, 8'h01, 8'h00);
			meas("pwm level", (i[0] ^ i[1]) ? 64 : 192, 256);
		end
		start(mk(MODE_PWM, PWM_WAVE, 1'b1, 1'b0, 1'b0, 1'b0), 16'd300, 8'h01, 8'h00);
		repeat (20) @(posedge sys_clk);
		q = rises;
		repeat (600) @(posedge sys_clk);
		chk("full duty edges", q, rises);
		chk("full duty level", 32'h1, {31'h0, line});
		start(mk(MODE_PWM, PWM_WAVE, 1'b1, 1'b0, 1'b1, 1'b0), 16'd512, 8'h01, 8'h00);
		meas("pwm swap", 256, 512);
		start(mk(MODE_PWM, PWM_WAVE, 1'b1, 1'b0, 1'b0, 1'b0), 16'd64, 8'h01, 8'h01);
		meas("pwm ratio", 128, 512);
		for (int i = 0; i < 2; i++) begin
			start(mk(MODE_PWM, 2'(i), 1'b1, 1'b0, 1'b0, 1'b0), 16'd64, 8'h01, 8'h00);
			repeat (300) @(posedge sys_clk);
			chk("forced level", 32'(i), {31'h0, timer_output_pin});
			rd(OFS_STATUS, 32'h3, "pwm flags");
		end
		start(mk(MODE_COMPARE, PIN_HOLD, 1'b0, 1'b0, 1'b0, 1'b0), 16'd100, 8'h00, 8'h00);
		repeat (65000) @(posedge sys_clk);
		rd(OFS_STATUS, 32'h1, "no early p match");
		repeat (700) @(posedge sys_clk);
		rd(OFS_STATUS, 32'h3, "overflow p match");
		$display("test overflow done");
		end_sim();
	end
endmodule
